// >>> rtl/error_counter.sv
/*
 * parity and bit error checker with BCD error and bit interval counters.
 * assumes all inputs synchronous to sys_clk_i; bit timing and external bit
 * clock are once-per-bit levels whose rising edge marks a bit.
 */
// Local design decisions: the AXI4-Lite register port and the address map.
`timescale 1ns/10ps
`default_nettype none
module error_counter
	import error_counter_pkg::*;
#(
	parameter int unsigned DELAY_CYCLES = AUTO_DELAY_CYCLES
) (
	input wire logic sys_clk_i,
	input wire logic resetn_i,
	input wire logic line_signal_i,
	input wire logic bit_timing_i,
	input wire logic ext_bit_clk_i,
	input wire logic xfer_gate_pulse_i,
	input wire logic char_start_i,
	input wire logic [3:0] awaddr_i,
	input wire logic awvalid_i,
	output logic awready_o,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] wstrb_i,
	input wire logic wvalid_i,
	output logic wready_o,
	output logic [1:0] bresp_o,
	output logic bvalid_o,
	input wire logic bready_i,
	input wire logic [3:0] araddr_i,
	input wire logic arvalid_i,
	output logic arready_o,
	output logic [31:0] rdata_o,
	output logic [1:0] rresp_o,
	output logic rvalid_o,
	input wire logic rready_i,
	output logic [9:0] slot_n_o,
	output logic error_pulse_o,
	output logic test_sig_o,
	output logic parity_err_o,
	output logic [7:0] bcd_count_o,
	output logic overflow_o,
	output logic count_done_o
);

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!resetn_i);

	function automatic logic [2:0] decode_reg(input logic [3:0] addr);
		// bit 2 of result flags a valid word address
		decode_reg = {addr[1:0] == 2'b00, addr[3:2]};
	endfunction : decode_reg

	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		if (v[3:0] == 4'h9) begin
			bcd_inc = {v[7:4] + 4'h1, 4'h0};
		end else begin
			bcd_inc = {v[7:4], v[3:0] + 4'h1};
		end
	endfunction : bcd_inc

	function automatic logic [19:0] interval_len(input logic [2:0] sel);
		case (sel)
			3'h0: interval_len = LEN_E2;
			3'h1: interval_len = LEN_E3;
			3'h2: interval_len = LEN_E4;
			3'h3: interval_len = LEN_E5;
			default: interval_len = LEN_E6;
		endcase
	endfunction : interval_len

	ctrl_t ctrl_reg;
	logic [2:0] cmd_reg;
	logic aw_held_reg, w_held_reg, aw_held_next, w_held_next;
	logic [3:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic aw_hs, w_hs, ar_hs, do_write, rvalid_next;
	logic [2:0] wdec, rdec;
	logic tick_src, tick_prev_reg, bit_tick;
	logic [3:0] slot_reg, slot_next;
	logic st_prev_reg, st_fall, par_acc_reg, pfault_reg;
	logic [8:0] pat_reg;
	logic pat_exp, miss_reg;
	logic [3:0] sync_cnt_reg;
	logic sync_hold;
	logic [7:0] err_bcd_reg;
	logic [19:0] interval_reg;
	logic frozen, count_en, err_pulse, err_step, hit_ovf, hit_done;
	logic [27:0] timer_reg;
	logic count_clear_reg;

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite slave

	assign aw_hs = awvalid_i & awready_o;
	assign w_hs = wvalid_i & wready_o;
	assign ar_hs = arvalid_i & arready_o;
	// write waits while a response is still unaccepted
	assign do_write = aw_held_reg & w_held_reg & ~bvalid_o;
	assign aw_held_next = do_write ? 1'b0 : (aw_hs | aw_held_reg);
	assign w_held_next = do_write ? 1'b0 : (w_hs | w_held_reg);
	assign wdec = decode_reg(awaddr_reg);
	assign rdec = decode_reg(araddr_i);
	assign rvalid_next = ar_hs | (rvalid_o & ~rready_i);

	// address and data captured in either order
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			awready_o <= 1'b0;
			wready_o <= 1'b0;
			awaddr_reg <= 4'h0;
			wdata_reg <= 32'h0;
			wstrb_reg <= 4'h0;
		end else begin
			aw_held_reg <= aw_held_next;
			w_held_reg <= w_held_next;
			awready_o <= ~aw_held_next;
			wready_o <= ~w_held_next;
			if (aw_hs) begin
				awaddr_reg <= awaddr_i;
			end
			if (w_hs) begin
				wdata_reg <= wdata_i;
				wstrb_reg <= wstrb_i;
			end
		end
	end

	// write response, slave error on an address that is not word aligned
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			bvalid_o <= 1'b0;
			bresp_o <= RESP_OKAY;
		end else if (do_write) begin
			bvalid_o <= 1'b1;
			bresp_o <= wdec[2] ? RESP_OKAY : RESP_SLVERR;
		end else if (bready_i) begin
			bvalid_o <= 1'b0;
		end
	end

	// control register and one-cycle command pulses
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			ctrl_reg <= CTRL_RESET;
			cmd_reg <= 3'h0;
		end else begin
			cmd_reg <= 3'h0;
			if (do_write && wdec == {1'b1, REG_CTRL} && wstrb_reg[0]) begin
				ctrl_reg <= wdata_reg[7:0];
			end
			if (do_write && wdec == {1'b1, REG_CMD} && wstrb_reg[0]) begin
				cmd_reg <= wdata_reg[2:0];
			end
		end
	end

	// read path, one cycle from address to data
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			arready_o <= 1'b0;
			rvalid_o <= 1'b0;
			rdata_o <= 32'h0;
			rresp_o <= RESP_OKAY;
		end else begin
			arready_o <= ~rvalid_next;
			rvalid_o <= rvalid_next;
			if (ar_hs) begin
				rresp_o <= rdec[2] ? RESP_OKAY : RESP_SLVERR;
				unique case ({rdec[2], rdec[1:0]})
					{1'b1, REG_CTRL}: rdata_o <= {24'h0, ctrl_reg};
					{1'b1, REG_STATUS}: rdata_o <= {20'h0, sync_hold,
						parity_err_o, count_done_o, overflow_o, err_bcd_reg};
					{1'b1, REG_INTERVAL}: rdata_o <= {12'h0, interval_reg};
					default: rdata_o <= 32'h0;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bit tick and transition slots

	assign tick_src = ctrl_reg.ext_clk_sel ? ext_bit_clk_i : bit_timing_i;
	assign bit_tick = tick_src & ~tick_prev_reg;

	// slot restarts at each start element, stops at the last slot
	always_comb begin
		slot_next = slot_reg;
		if (char_start_i) begin
			slot_next = 4'h0;
		end else if (bit_tick && slot_reg != LAST_SLOT) begin
			slot_next = slot_reg + 4'h1;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			tick_prev_reg <= 1'b0;
			slot_reg <= LAST_SLOT;
		end else begin
			tick_prev_reg <= tick_src;
			slot_reg <= slot_next;
		end
	end

	// one-cold slot lines, each low in its own slot
	generate
		for (genvar i = 0; i < 10; i++) begin : g_slot
			always_ff @(posedge sys_clk_i) begin
				if (!resetn_i) begin
					// reset parks the counter on the last slot
					slot_n_o[i] <= (4'(i) != LAST_SLOT);
				end else begin
					slot_n_o[i] <= (slot_next != 4'(i));
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// parity checker

	assign st_fall = st_prev_reg & ~xfer_gate_pulse_i;

	// start element is space, so counting it from slot 0 adds nothing
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			st_prev_reg <= 1'b0;
			par_acc_reg <= 1'b0;
			pfault_reg <= 1'b0;
		end else begin
			st_prev_reg <= xfer_gate_pulse_i;
			if (char_start_i) begin
				par_acc_reg <= 1'b0;
			end else if (bit_tick && slot_n_o[9]) begin
				par_acc_reg <= par_acc_reg ^ line_signal_i;
			end
			// acc high means odd Mark count
			pfault_reg <= st_fall & (par_acc_reg ^ ctrl_reg.odd_sense);
		end
	end

	// sticky indicator, a new fault beats the operator clear
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			parity_err_o <= 1'b0;
		end else begin
			parity_err_o <= pfault_reg |
				(parity_err_o & ~cmd_reg[CMD_PAR_CLR]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pattern checker

	// shifting in received bits makes the generator self-aligning
	assign pat_exp = ctrl_reg.prbs_sel ? ^(pat_reg & PRBS_POLY) : ~pat_reg[0];
	assign sync_hold = (sync_cnt_reg != 4'h0);

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			pat_reg <= PAT_SEED;
			sync_cnt_reg <= 4'h0;
			miss_reg <= 1'b0;
		end else begin
			miss_reg <= 1'b0;
			if (cmd_reg[CMD_SYNC]) begin
				sync_cnt_reg <= SYNC_BITS;
			end else if (bit_tick && sync_hold) begin
				sync_cnt_reg <= sync_cnt_reg - 4'h1;
			end
			if (bit_tick) begin
				pat_reg <= {pat_reg[7:0], sync_hold ? line_signal_i : pat_exp};
				miss_reg <= ctrl_reg.mode_pattern & ~sync_hold &
					(line_signal_i != pat_exp);
			end
		end
	end

	// external outputs of the pattern checker
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			error_pulse_o <= 1'b0;
			test_sig_o <= 1'b0;
		end else begin
			error_pulse_o <= miss_reg;
			test_sig_o <= pat_exp;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// error and interval counters

	assign frozen = overflow_o | count_done_o;
	assign count_en = ~frozen & ~sync_hold & ~count_clear_reg;
	assign err_pulse = ctrl_reg.mode_pattern ? miss_reg : pfault_reg;
	assign err_step = count_en & err_pulse;
	assign hit_ovf = err_step & (bcd_inc(err_bcd_reg) == ERR_LIMIT);
	assign hit_done = count_en & bit_tick & ~hit_ovf &
		(interval_reg + 20'h1 == interval_len(ctrl_reg.interval_sel));

	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			err_bcd_reg <= 8'h0;
			interval_reg <= 20'h0;
		end else if (count_clear_reg) begin
			err_bcd_reg <= 8'h0;
			interval_reg <= 20'h0;
		end else begin
			if (err_step) begin
				err_bcd_reg <= bcd_inc(err_bcd_reg);
			end
			if (count_en && bit_tick) begin
				interval_reg <= interval_reg + 20'h1;
			end
		end
	end

	// completion flags, the first finisher wins
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			overflow_o <= 1'b0;
			count_done_o <= 1'b0;
			bcd_count_o <= 8'h0;
		end else begin
			overflow_o <= hit_ovf | (overflow_o & ~count_clear_reg);
			count_done_o <= hit_done | (count_done_o & ~count_clear_reg);
			bcd_count_o <= count_clear_reg ? 8'h0 :
				(err_step ? bcd_inc(err_bcd_reg) : err_bcd_reg);
		end
	end

	// reset timer; manual reset only counts with auto off
	always_ff @(posedge sys_clk_i) begin
		if (!resetn_i) begin
			timer_reg <= 28'h0;
			count_clear_reg <= 1'b0;
		end else begin
			count_clear_reg <= 1'b0;
			if (!frozen || !ctrl_reg.auto_reset || count_clear_reg) begin
				timer_reg <= 28'h0;
			end else if (timer_reg == 28'(DELAY_CYCLES - 1)) begin
				timer_reg <= 28'h0;
				count_clear_reg <= 1'b1;
			end else begin
				timer_reg <= timer_reg + 28'h1;
			end
			if (!ctrl_reg.auto_reset && cmd_reg[CMD_MAN_RESET]) begin
				count_clear_reg <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	parity_fault_a: assert property (
		st_fall |=> pfault_reg == $past(par_acc_reg ^ ctrl_reg.odd_sense))
		else $error("parity fault pulse wrong");
	parity_clear_a: assert property (
		char_start_i |=> !par_acc_reg)
		else $error("parity state not cleared");
	sticky_parity_a: assert property (
		pfault_reg |=> parity_err_o ##1
		(parity_err_o || $past(cmd_reg[CMD_PAR_CLR])))
		else $error("parity indicator not sticky");
	miss_out_a: assert property (
		miss_reg |=> error_pulse_o ##1 !error_pulse_o || $past(miss_reg))
		else $error("error pulse output wrong");
	sync_freeze_a: assert property (
		sync_hold && !count_clear_reg |=> $stable(err_bcd_reg))
		else $error("counting during sync");
	overflow_set_a: assert property (
		hit_ovf |=> overflow_o && err_bcd_reg == 8'h51)
		else $error("overflow not flagged at 51");
	one_flag_a: assert property (
		!(overflow_o && count_done_o))
		else $error("both completion flags set");
	frozen_count_a: assert property (
		frozen && !count_clear_reg |=> $stable(err_bcd_reg) &&
		$stable(interval_reg) && frozen)
		else $error("counters moved while complete");
	clear_all_a: assert property (
		count_clear_reg |=> err_bcd_reg == 8'h0 && interval_reg == 20'h0
		&& !overflow_o && !count_done_o)
		else $error("count clear incomplete");
	manual_only_a: assert property (
		$rose(count_clear_reg) && !$past(ctrl_reg.auto_reset) |->
		$past(cmd_reg[CMD_MAN_RESET]))
		else $error("clear without manual reset");

	overflow_c: cover property ($rose(overflow_o));
	done_c: cover property ($rose(count_done_o));
	parity_c: cover property (pfault_reg && !ctrl_reg.mode_pattern);
	miss_c: cover property (miss_reg ##[1:20] count_clear_reg);

endmodule : error_counter
`default_nettype wire

// >>> rtl/error_counter_pkg.sv
/*
 * constants, field layouts and register map of the telegraph error counter.
 * assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package error_counter_pkg;

	localparam int unsigned CLK_HZ = 50_000_000;
	localparam int unsigned AUTO_DELAY_S = 5;
	localparam int unsigned AUTO_DELAY_CYCLES = AUTO_DELAY_S * CLK_HZ;

	// register byte offsets
	localparam logic [3:0] CTRL_OFS = 4'h0;
	localparam logic [3:0] CMD_OFS = 4'h4;
	localparam logic [3:0] STATUS_OFS = 4'h8;
	localparam logic [3:0] INTERVAL_OFS = 4'hc;

	// command bits
	localparam int CMD_PAR_CLR = 0;
	localparam int CMD_MAN_RESET = 1;
	localparam int CMD_SYNC = 2;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// pattern generator
	localparam int PAT_LEN = 9;
	localparam logic [8:0] PRBS_POLY = 9'h110;
	localparam logic [8:0] PAT_SEED = 9'h1ff;
	localparam logic [3:0] SYNC_BITS = 4'h9;

	localparam logic [7:0] ERR_LIMIT = 8'h51;
	localparam logic [3:0] LAST_SLOT = 4'h9;

	localparam logic [19:0] LEN_E2 = 20'h00064;
	localparam logic [19:0] LEN_E3 = 20'h003e8;
	localparam logic [19:0] LEN_E4 = 20'h02710;
	localparam logic [19:0] LEN_E5 = 20'h186a0;
	localparam logic [19:0] LEN_E6 = 20'hf4240;

	typedef struct packed {
		logic [2:0] interval_sel;
		logic prbs_sel;
		logic ext_clk_sel;
		logic auto_reset;
		logic odd_sense;
		logic mode_pattern;
	} ctrl_t;

	localparam ctrl_t CTRL_RESET = 8'h04;

	typedef enum logic [1:0] {
		REG_CTRL = 2'b00,
		REG_CMD = 2'b01,
		REG_STATUS = 2'b10,
		REG_INTERVAL = 2'b11
	} reg_sel_t;

endpackage : error_counter_pkg

// >>> verification/line_model.sv
/*
 * behavioural model of the telegraph data line under test: line level,
 * once-per-bit timing, external bit clock, character start and transfer gate.
 * assumes the caller runs its tasks from one process, clocked by clk_i.
 */
`timescale 1ns/10ps
`default_nettype none
module line_model (
	input wire logic clk_i,
	output logic line_o,
	output logic bit_timing_o,
	output logic ext_clk_o,
	output logic char_start_o,
	output logic xfer_gate_o
);
	// steers ticks to the external clock pin instead of internal timing
	logic use_ext;

	// idle line rests at mark, all strobes low
	initial begin
		use_ext = 1'b0;
		line_o = 1'b1;
		bit_timing_o = 1'b0;
		ext_clk_o = 1'b0;
		char_start_o = 1'b0;
		xfer_gate_o = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// one bit of four clocks, tick rises mid-bit so the level is settled
	task automatic bit_out(input logic v);
		@(posedge clk_i);
		line_o <= v;
		@(posedge clk_i);
		if (use_ext) begin
			ext_clk_o <= 1'b1;
		end else begin
			bit_timing_o <= 1'b1;
		end
		@(posedge clk_i);
		ext_clk_o <= 1'b0;
		bit_timing_o <= 1'b0;
		@(posedge clk_i);
		#1;
	endtask : bit_out

	////////////////////////////////////////////////////////////////////////
	// start element, eight data bits lsb first, stop, then gate falls
	task automatic send_char(input logic [7:0] d);
		@(posedge clk_i);
		line_o <= 1'b0;
		char_start_o <= 1'b1;
		@(posedge clk_i);
		char_start_o <= 1'b0;
		bit_out(1'b0);
		for (int i = 0; i < 8; i++) begin
			bit_out(d[i]);
		end
		bit_out(1'b1);
		// gate falls while the stop element still stands on the line
		@(posedge clk_i);
		xfer_gate_o <= 1'b1;
		@(posedge clk_i);
		xfer_gate_o <= 1'b0;
		repeat (3) @(posedge clk_i);
		#1;
	endtask : send_char
endmodule : line_model
`default_nettype wire

// >>> verification/telegraph_error_counter_tb.sv
/*
 * self-checking bench for the error counter: register tasks over the bus,
 * line traffic from the line model, expected values from the rules.
 * assumes a shortened auto reset delay so the run stays brief.
 */
`timescale 1ns/10ps
`default_nettype none
module telegraph_error_counter_tb;
	import error_counter_pkg::*;
	localparam int DLY = 400;
	// any non-zero word primes the generator during sync
	localparam logic [8:0] PRBS_SYNC = 9'h0b5;
	logic sys_clk_i, resetn_i, awvalid, wvalid, bready, arvalid, rready;
	logic awready, wready, bvalid, arready, rvalid;
	logic [3:0] awaddr, araddr, wstrb;
	logic [31:0] wdata, rdata, rd_data;
	logic [1:0] bresp, rresp, resp;
	logic line, bt, ext, start, gate, err_pulse, test_sig, par_err, ovf, done;
	logic [9:0] slot_n;
	logic [7:0] bcd;
	int error_cnt, compares, ep_cnt, n;
	logic [8:0] pref;
	logic pb;

	line_model lm (.clk_i(sys_clk_i), .line_o(line), .bit_timing_o(bt),
		.ext_clk_o(ext), .char_start_o(start), .xfer_gate_o(gate));

	error_counter #(.DELAY_CYCLES(DLY)) dut (.sys_clk_i(sys_clk_i),
		.resetn_i(resetn_i), .line_signal_i(line), .bit_timing_i(bt),
		.ext_bit_clk_i(ext), .xfer_gate_pulse_i(gate), .char_start_i(start),
		.awaddr_i(awaddr), .awvalid_i(awvalid), .awready_o(awready),
		.wdata_i(wdata), .wstrb_i(wstrb), .wvalid_i(wvalid),
		.wready_o(wready), .bresp_o(bresp), .bvalid_o(bvalid),
		.bready_i(bready), .araddr_i(araddr), .arvalid_i(arvalid),
		.arready_o(arready), .rdata_o(rdata), .rresp_o(rresp),
		.rvalid_o(rvalid), .rready_i(rready), .slot_n_o(slot_n),
		.error_pulse_o(err_pulse), .test_sig_o(test_sig),
		.parity_err_o(par_err), .bcd_count_o(bcd), .overflow_o(ovf),
		.count_done_o(done));

	// 50 MHz clock
	initial begin
		sys_clk_i = 1'b0;
		forever #10 sys_clk_i = ~sys_clk_i;
	end

	// counts one-cycle miss pulses at the pin
	always @(posedge sys_clk_i) begin
		if (err_pulse === 1'b1) ep_cnt++;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t ns: got %h expected %h", $time, got,
				exp);
		end
	endtask : chk

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : conclude

	// a bus wait that never ends is a failure, not a hang
	task automatic stall();
		error_cnt++;
		conclude();
	endtask : stall

	task automatic wr(input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] s = 4'hf);
		@(posedge sys_clk_i);
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge sys_clk_i);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
			if (bvalid === 1'b1) break;
		end
		if (n == 100) stall();
		resp = bresp;
		bready <= 1'b0;
		#1;
	endtask : wr

	task automatic rd(input logic [3:0] a);
		@(posedge sys_clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge sys_clk_i);
			if (arready === 1'b1) arvalid <= 1'b0;
			if (rvalid === 1'b1) break;
		end
		if (n == 100) stall();
		rd_data = rdata;
		resp = rresp;
		rready <= 1'b0;
		#1;
	endtask : rd

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		{awaddr, araddr, wdata} = 40'h0;
		wstrb = 4'hf;
		resetn_i = 1'b0;
		error_cnt = 0;
		compares = 0;
		ep_cnt = 0;
		repeat (5) @(posedge sys_clk_i);
		resetn_i <= 1'b1;
		repeat (2) @(posedge sys_clk_i);
		#1;
		chk(slot_n, 10'h1ff);
		rd(CTRL_OFS);
		chk(rd_data, 32'h04);
		rd(4'h2);
		chk(resp, RESP_SLVERR);
		wr(4'h2, 32'h0);
		chk(resp, RESP_SLVERR);
		// low byte strobe off: control must keep its reset value
		wr(CTRL_OFS, 32'h83, 4'h0);
		rd(CTRL_OFS);
		chk(rd_data, 32'h04);
		// parity, even sense, auto reset off, longest interval
		wr(CTRL_OFS, 32'h80);
		chk(resp, RESP_OKAY);
		lm.send_char(8'h01);
		chk(par_err, 1'b1);
		chk(bcd, 8'h01);
		chk(slot_n, 10'h1ff);
		lm.send_char(8'h03);
		chk(bcd, 8'h01);
		wr(CMD_OFS, 32'h01);
		chk(par_err, 1'b0);
		wr(CTRL_OFS, 32'h82);
		lm.send_char(8'h03);
		chk(bcd, 8'h02);
		lm.send_char(8'h07);
		chk(bcd, 8'h02);
		// walk the bcd count up to its limit through every carry
		wr(CTRL_OFS, 32'h80);
		for (int i = 2; i < 51; i++) lm.send_char(8'h01);
		chk(bcd, 8'h51);
		chk({ovf, done}, 2'b10);
		lm.send_char(8'h01);
		repeat (DLY + 20) @(posedge sys_clk_i);
		#1;
		chk({ovf, bcd}, 9'h151);
		rd(STATUS_OFS);
		chk(rd_data, 32'h551);
		wr(CMD_OFS, 32'h02);
		// clear pulse follows the command, outputs one edge later
		@(posedge sys_clk_i);
		#1;
		chk({ovf, bcd}, 9'h000);
		// interval of 100 external ticks, then automatic clear
		wr(CTRL_OFS, 32'h0c);
		lm.use_ext = 1'b1;
		for (int i = 0; i < 99; i++) lm.bit_out(i[0]);
		chk(done, 1'b0);
		lm.bit_out(1'b0);
		chk({ovf, done}, 2'b01);
		lm.bit_out(1'b1);
		rd(INTERVAL_OFS);
		chk(rd_data, 32'h64);
		rd(STATUS_OFS);
		chk(rd_data & 32'h3ff, 32'h200);
		repeat (DLY / 2) @(posedge sys_clk_i);
		#1;
		chk(done, 1'b1);
		for (n = 0; n < DLY && done === 1'b1; n++) @(posedge sys_clk_i);
		#1;
		chk(done, 1'b0);
		rd(INTERVAL_OFS);
		chk(rd_data, 32'h0);
		lm.use_ext = 1'b0;
		// reversal pattern: sync, then one flipped bit gives one miss
		wr(CTRL_OFS, 32'h81);
		wr(CMD_OFS, 32'h02);
		wr(CMD_OFS, 32'h04);
		ep_cnt = 0;
		for (int i = 0; i < 30; i++) lm.bit_out(i[0] ^ (i == 20));
		repeat (3) @(posedge sys_clk_i);
		#1;
		chk(ep_cnt, 1);
		chk(bcd, 8'h01);
		// pseudo-random pattern against a reference built from the taps
		wr(CTRL_OFS, 32'h91);
		wr(CMD_OFS, 32'h04);
		ep_cnt = 0;
		for (int i = 0; i < 40; i++) begin
			pb = (i < 9) ? PRBS_SYNC[i] : ^(pref & PRBS_POLY);
			pref = {pref[7:0], pb};
			lm.bit_out(pb ^ (i == 30));
			if (i >= 8) chk(test_sig, ^(pref & PRBS_POLY));
		end
		repeat (3) @(posedge sys_clk_i);
		#1;
		chk(ep_cnt, 1);
		chk(bcd, 8'h02);
		conclude();
	end
endmodule : telegraph_error_counter_tb
`default_nettype wire
